// ### sim/sls_lane_tx.sv
// sls_lane_tx.sv: far-end lane model, code group then frame lock
// assumes: bench sets the wanted lock pattern on mclk
`timescale 1ns/1ps
`default_nettype none
module sls_lane_tx (
  input  wire        mclk,
  input  wire  [7:0] lk,
  output logic [7:0] cg,
  output logic [7:0] fr
);
  always @(posedge mclk) cg <= lk;
  // frame lock never runs ahead of code group lock
  always @(posedge mclk) fr <= cg & lk;
endmodule
`default_nettype wire

// ### sim/sls_status_bank_props.sv
// sls_status_bank_props.sv: timing checks on the lane status bank
// assumes: bound to sls_status_bank; clk_en low pauses the checks
`timescale 1ns/1ps
`default_nettype none
module sls_status_bank_props (
  input wire mclk, reset, clk_en, rd_en, rd_valid_q,
  input wire skip_initial_lane_alignment, frame_sync_ignore_q,
  input wire [11:0] rd_addr,
  input wire [7:0] rd_data_q, lane_error_threshold, frame_locked_flag,
  input wire [7:0] code_group_locked_flag, unexpected_control_char_flag_q,
  input wire [63:0] lane_err_count
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset || !clk_en);
  logic [7:0] c;
  logic [2:0] run_q;
  always_comb for (int n = 0; n < 8; n++)
    c[n] = lane_err_count[8*n+:8] >= lane_error_threshold;
  // enabled cycles since reset or a freeze, so the stages have filled
  always @(posedge mclk)
    if (reset || !clk_en) run_q <= 3'h0;
    else if (run_q != 3'h7) run_q <= run_q + 3'h1;
  flag_cmp_a: assert property ($stable(c)[*4] ##0 (run_q >= 3'h4)
    |-> unexpected_control_char_flag_q == c) else $error("flag vs count");
  rd_valid_a: assert property (rd_en |=> rd_valid_q) else $error("valid");
  ctrl_rd_a: assert property (rd_en && rd_addr == 12'h46F |=>
    rd_data_q == unexpected_control_char_flag_q) else $error("46F read");
  cg_rd_a: assert property ($stable(code_group_locked_flag)[*4] ##0
    (run_q >= 3'h4 && rd_en && rd_addr == 12'h470) |=>
    rd_data_q == $past(code_group_locked_flag)) else $error("470 read");
  frame_rd_a: assert property ($stable(frame_locked_flag)[*4] ##0
    (run_q >= 3'h4 && rd_en && rd_addr == 12'h471) |=>
    rd_data_q == $past(frame_locked_flag)) else $error("471 read");
  unmapped_a: assert property (rd_en && !(rd_addr inside {12'h46F,
    12'h470, 12'h471}) |=> rd_data_q == 8'h00) else $error("unmapped");
  ignore_a: assert property ($stable(skip_initial_lane_alignment)[*4]
    ##0 (run_q >= 3'h4)
    |-> frame_sync_ignore_q == skip_initial_lane_alignment) else $error("ign");
  rst_zero_a: assert property (disable iff (1'b0) reset && clk_en |=>
    !unexpected_control_char_flag_q && !rd_valid_q && rd_data_q == 8'h00)
    else $error("reset value");
  cover property (rd_en && rd_addr == 12'h470);
  cover property ($rose(frame_sync_ignore_q));
  cover property ($rose(|unexpected_control_char_flag_q));
endmodule
bind sls_status_bank sls_status_bank_props u_props (.*);
`default_nettype wire

// ### sim/sls_status_bank_test.sv
// sls_status_bank_test.sv: directed checks of the lane status bank
// assumes: lane model drives lock flags, bench drives counts and reads
`timescale 1ns/1ps
`default_nettype none
module sls_status_bank_test;
  logic mclk = 0, reset = 1, en = 1, rd_en = 0, skip = 1, rd_valid, ign;
  logic [11:0] rd_addr = 12'h000;
  logic [7:0] lk = 8'hFF, er = 8'h00, thr = 8'h00, rd_data, uf, cg, fr;
  logic [63:0] cnt;
  int err_total = 0, checked = 0;
  always #50 mclk = ~mclk;
  // lane n carries base count plus n, so one threshold splits the lanes
  for (genvar n = 0; n < 8; n++)
  begin : g
    assign cnt[8*n+:8] = er + 8'(n);
  end
  sls_lane_tx u_sls_lane_tx (.mclk(mclk), .lk(lk), .cg(cg), .fr(fr));
  sls_status_bank u_sls_status_bank (.mclk(mclk), .reset(reset),
    .clk_en(en), .lane_err_count(cnt), .lane_error_threshold(thr),
    .code_group_locked_flag(cg), .frame_locked_flag(fr),
    .skip_initial_lane_alignment(skip), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data_q(rd_data), .rd_valid_q(rd_valid),
    .unexpected_control_char_flag_q(uf), .frame_sync_ignore_q(ign));
  task automatic chk(string nm, logic [7:0] s, e);
    checked++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic rd(logic [11:0] a, logic [7:0] e);
    @(posedge mclk) rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge mclk) rd_en <= 1'b0;
    #1 chk("rd_valid", {7'h00, rd_valid}, 8'h01);
    chk("rd_data", rd_data, e);
  endtask
  task automatic t_uek;
    logic [7:0] ev [4] = '{8'h03, 8'h00, 8'h00, 8'hF8};
    logic [7:0] tv [4] = '{8'h05, 8'h00, 8'h08, 8'hFF};
    logic [7:0] e;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk) er <= ev[i];
      thr <= tv[i];
      repeat (4) @(posedge mclk);
      for (int n = 0; n < 8; n++) e[n] = ev[i] + 8'(n) >= tv[i];
      rd(12'h46F, e);
      chk("flags", uf, e);
    end
    $display("threshold test done");
  endtask
  task automatic t_sync;
    logic [7:0] pv [3] = '{8'hA5, 8'h5A, 8'h00};
    for (int i = 0; i < 3; i++)
    begin
      @(posedge mclk) lk <= pv[i];
      repeat (6) @(posedge mclk);
      #1 chk("ignore", {7'h00, ign}, 8'h00);
      rd(12'h470, pv[i]);
      rd(12'h471, pv[i]);
    end
    $display("sync test done");
  endtask
  task automatic t_misc;
    @(posedge mclk) skip <= 1'b1;
    lk <= 8'hFF;
    repeat (6) @(posedge mclk);
    #1 chk("ignore", {7'h00, ign}, 8'h01);
    rd(12'h471, 8'hFF);
    rd(12'h472, 8'h00);
    rd(12'h46E, 8'h00);
    // clock enable low: nothing is taken, flags hold
    @(posedge mclk) en <= 1'b0;
    thr <= 8'h00;
    lk <= 8'h3C;
    rd_en <= 1'b1;
    rd_addr <= 12'h470;
    repeat (6) @(posedge mclk);
    rd_en <= 1'b0;
    #1 chk("frz_valid", {7'h00, rd_valid}, 8'h00);
    chk("frz_data", rd_data, 8'h00);
    chk("frz_flags", uf, 8'h80);
    @(posedge mclk) en <= 1'b1;
    repeat (4) @(posedge mclk);
    #1 chk("flags", uf, 8'hFF);
    rd(12'h470, 8'h3C);
    $display("ignore and unmapped test done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #300000;
    err_total++;
    finish_test;
  end
  initial
  begin
    // inputs all say locked and at or over threshold while reset holds
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    skip <= 1'b0;
    #1 chk("flags", uf, 8'h00);
    chk("rd_data", rd_data, 8'h00);
    chk("ignore", {7'h00, ign}, 8'h00);
    $display("reset test done");
    t_uek;
    t_sync;
    t_misc;
    finish_test;
  end
endmodule
`default_nettype wire

// ### verilog/sls_consts.vh
// sls_consts.vh: offsets, widths and reset values of the lane status bank
// assumes: included by the lane status modules, definitions only
`ifndef SLS_CONSTS_VH
`define SLS_CONSTS_VH
`define SLS_ADDR_W        12
`define SLS_DATA_W        8
`define SLS_LANES         8
`define SLS_CNT_W         8
`define SLS_OFF_CTRL      12'h46F
`define SLS_OFF_CG        12'h470
`define SLS_OFF_FRAME     12'h471
`define SLS_RST_CTRL      8'h00
`define SLS_RST_CG        8'h00
`define SLS_RST_FRAME     8'h00
`define SLS_RD_UNMAPPED   8'h00
`endif

// ### verilog/sls_lane_cmp.v
// sls_lane_cmp.v: one lane, error count against threshold, registered
// assumes: count and threshold are synchronous to mclk
`include "sls_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module sls_lane_cmp
(
  input  wire                   mclk,
  input  wire                   reset,
  input  wire                   clk_en,
  input  wire [`SLS_CNT_W-1:0]  err_count,
  input  wire [`SLS_CNT_W-1:0]  lane_error_threshold,
  output reg                    flag_q
);
  wire flag_d;
  // at or above threshold sets, below clears
  assign flag_d = (err_count >= lane_error_threshold);
  always @(posedge mclk)
  begin
    if (reset)
      flag_q <= 1'b0;
    else if (clk_en)
      flag_q <= flag_d;
  end
endmodule
`default_nettype wire

// ### verilog/sls_status_bank.v
// sls_status_bank.v: read-only lane status registers for the serial link
// assumes: lane sync levels come from the lane receivers in another
// domain; error counts and threshold are on mclk; reads are by address
//
// Contract
// - unexpected control flag set when count >= threshold
// - control flags read-only, reset to zero
// - code group sync register, bit n lane n
// - code group sync bits read-only, reset zero
// - frame sync register, bit 7 lane 7
// - control flags at 0x46F, lanes 7 and 6 too
// - frame sync bits 6..0 lanes 6..0
`include "sls_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module sls_status_bank
(
  input  wire                                mclk,
  input  wire                                reset,
  input  wire                                clk_en,
  input  wire [`SLS_LANES*`SLS_CNT_W-1:0]    lane_err_count,
  input  wire [`SLS_CNT_W-1:0]               lane_error_threshold,
  input  wire [`SLS_LANES-1:0]               code_group_locked_flag,
  input  wire [`SLS_LANES-1:0]               frame_locked_flag,
  input  wire                                skip_initial_lane_alignment,
  input  wire                                rd_en,
  input  wire [`SLS_ADDR_W-1:0]              rd_addr,
  output reg  [`SLS_DATA_W-1:0]              rd_data_q,
  output reg                                 rd_valid_q,
  output reg  [`SLS_LANES-1:0]               unexpected_control_char_flag_q,
  output reg                                 frame_sync_ignore_q
);
  // clk_en low holds every flop, the sync stages included
  localparam [1:0] SEL_NONE  = 2'b00;
  localparam [1:0] SEL_CTRL  = 2'b01;
  localparam [1:0] SEL_CG    = 2'b10;
  localparam [1:0] SEL_FRAME = 2'b11;

  // per-bit reset values, indexed by lane
  localparam [`SLS_LANES-1:0] RST_CTRL  = `SLS_RST_CTRL;
  localparam [`SLS_LANES-1:0] RST_CG    = `SLS_RST_CG;
  localparam [`SLS_LANES-1:0] RST_FRAME = `SLS_RST_FRAME;

  wire [`SLS_LANES-1:0]  ctrl_flag_w;
  wire [`SLS_LANES-1:0]  cg_sync_w;
  wire [`SLS_LANES-1:0]  frame_sync_w;
  wire [1:0]             rd_sel_w;
  wire                   rd_hit_w;
  reg                    skip_meta_q;
  reg                    skip_q;
  reg  [`SLS_DATA_W-1:0] rd_data_d;
  reg                    rd_valid_d;
  reg  [`SLS_LANES-1:0]  ctrl_flag_d;
  reg                    ignore_d;

  // one decoder serves the read mux and the mapped check
  function [1:0] sls_decode;
    input [`SLS_ADDR_W-1:0] addr;
    begin
      if (addr == `SLS_OFF_CTRL)
        sls_decode = SEL_CTRL;
      else if (addr == `SLS_OFF_CG)
        sls_decode = SEL_CG;
      else if (addr == `SLS_OFF_FRAME)
        sls_decode = SEL_FRAME;
      else
        sls_decode = SEL_NONE;
    end
  endfunction

  assign rd_sel_w = sls_decode(rd_addr);
  assign rd_hit_w = (sls_decode(rd_addr) != SEL_NONE);

  // per lane: threshold compare and two-stage sync of lock levels
  genvar g;
  generate
    for (g = 0; g < `SLS_LANES; g = g + 1)
    begin : g_lane
      reg cg_meta_q;
      reg cg_q;
      reg frame_meta_q;
      reg frame_q;

      // threshold 0 flags every lane; counts wrap inside the counter
      sls_lane_cmp u_sls_lane_cmp
      (
        .mclk                 (mclk),
        .reset                (reset),
        .clk_en               (clk_en),
        .err_count            (lane_err_count[g*`SLS_CNT_W +: `SLS_CNT_W]),
        .lane_error_threshold (lane_error_threshold),
        .flag_q               (ctrl_flag_w[g])
      );

      // code group lock comes from a receiver clock; meta stage unread
      always @(posedge mclk)
      begin
        if (reset)
        begin
          cg_meta_q <= RST_CG[g];
          cg_q      <= RST_CG[g];
        end
        else if (clk_en)
        begin
          cg_meta_q <= code_group_locked_flag[g];
          cg_q      <= cg_meta_q;
        end
      end

      // frame lock, same two stages
      always @(posedge mclk)
      begin
        if (reset)
        begin
          frame_meta_q <= RST_FRAME[g];
          frame_q      <= RST_FRAME[g];
        end
        else if (clk_en)
        begin
          frame_meta_q <= frame_locked_flag[g];
          frame_q      <= frame_meta_q;
        end
      end

      assign cg_sync_w[g]    = cg_q;
      assign frame_sync_w[g] = frame_q;
    end
  endgenerate

  // skip setting is a pin level; synced like the lock levels
  always @(posedge mclk)
  begin
    if (reset)
    begin
      skip_meta_q <= 1'b0;
      skip_q      <= 1'b0;
    end
    else if (clk_en)
    begin
      skip_meta_q <= skip_initial_lane_alignment;
      skip_q      <= skip_meta_q;
    end
  end

  // read mux; no write path exists, so every bit is read-only
  always @*
  begin
    // other addresses read zero, never an error
    rd_data_d = `SLS_RD_UNMAPPED;
    if (rd_hit_w)
    begin
      case (rd_sel_w)
        SEL_CTRL:  rd_data_d = ctrl_flag_w;
        SEL_CG:    rd_data_d = cg_sync_w;
        SEL_FRAME: rd_data_d = frame_sync_w;
        default:   rd_data_d = `SLS_RD_UNMAPPED;
      endcase
    end
  end

  // next values of the output registers
  always @*
  begin
    rd_valid_d  = rd_en;
    ctrl_flag_d = ctrl_flag_w;
    // frame sync still reported; this flag tells software to ignore it
    ignore_d    = skip_q;
  end

  // read data holds until the next taken read
  always @(posedge mclk)
  begin
    if (reset)
    begin
      rd_data_q <= `SLS_RD_UNMAPPED;
    end
    else if (clk_en && rd_en)
    begin
      rd_data_q <= rd_data_d;
    end
  end

  always @(posedge mclk)
  begin
    if (reset)
    begin
      rd_valid_q <= 1'b0;
    end
    else if (clk_en)
    begin
      rd_valid_q <= rd_valid_d;
    end
  end

  always @(posedge mclk)
  begin
    if (reset)
    begin
      unexpected_control_char_flag_q <= RST_CTRL;
    end
    else if (clk_en)
    begin
      unexpected_control_char_flag_q <= ctrl_flag_d;
    end
  end

  always @(posedge mclk)
  begin
    if (reset)
    begin
      frame_sync_ignore_q <= 1'b0;
    end
    else if (clk_en)
    begin
      frame_sync_ignore_q <= ignore_d;
    end
  end
endmodule
`default_nettype wire
